// file: rtl/asc_pkg.sv
package asc_pkg;
  // ============================================================
  // Register map
  localparam logic [3:0]  ASC_OFF_REF_EN    = 4'h0;
  localparam logic [3:0]  ASC_OFF_SCAN_LO   = 4'h2;
  localparam logic [3:0]  ASC_OFF_SCAN_HI   = 4'h4;
  localparam logic [3:0]  ASC_OFF_CLK_DIV   = 4'h6;
  localparam logic [3:0]  ASC_OFF_SCAN_STAT = 4'h8;
  // ============================================================
  // Field positions
  localparam int          ASC_BIT_FULL_REF  = 0;
  localparam int          ASC_BIT_HALF_REF  = 1;
  localparam int          ASC_BIT_SIXTH_REF = 2;
  localparam int          ASC_CH_HALF_REF   = 24;
  localparam int          ASC_CH_FULL_REF   = 25;
  localparam int          ASC_CH_CORE_V     = 26;
  localparam int          ASC_CH_SIXTH_REF  = 27;
  localparam int          ASC_NUM_CH        = 28;
  // ============================================================
  // Masks and resets
  localparam logic [15:0] ASC_REF_MASK      = 16'h0007;
  localparam logic [15:0] ASC_HI_MASK_FULL  = 16'h0fff;
  localparam logic [15:0] ASC_HI_MASK_SMALL = 16'h0f00;
  localparam logic [15:0] ASC_RESET_VAL     = 16'h0000;
  localparam logic [7:0]  ASC_DIV_RESET     = 8'h00;
  // ============================================================
  // Positive input selector codes
  localparam logic [4:0]  ASC_SEL_HALF_REF  = 5'h18;
  localparam logic [4:0]  ASC_SEL_FULL_REF  = 5'h19;
  localparam logic [4:0]  ASC_SEL_CORE_V    = 5'h1a;
  localparam logic [4:0]  ASC_SEL_SIXTH_REF = 5'h1b;
  localparam logic [4:0]  ASC_SEL_NONE      = 5'h1f;
  // Oscillator periods per instruction cycle
  localparam int          ASC_OSC_PER_CYC   = 2;
endpackage : asc_pkg

// file: rtl/asc_clk_if.sv
`timescale 1ns/1ps
interface asc_clk_if;
  logic [7:0] divider;
  logic       tick;
  modport gen (input divider, output tick);
  modport use_side (output divider, input tick);
endinterface : asc_clk_if

// file: rtl/asc_conv_clk.sv
`timescale 1ns/1ps
module asc_conv_clk
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Divider link
  asc_clk_if.gen    cif
);
  logic [8:0] osc_cnt;
  logic [8:0] next_osc_cnt;
  logic [8:0] limit;
  logic       tick_q;
  logic       next_tick;

  // ============================================================
  // Period = osc_per_cyc * (divider + 1) clk_sys cycles
  always_comb
  begin
    limit        = 9'((int'(cif.divider) + 1) * ASC_OSC_PER_CYC - 1);
    next_tick    = (osc_cnt >= limit);
    next_osc_cnt = next_tick ? 9'h000 : 9'(osc_cnt + 9'h001);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_cnt <= 9'h000;
      tick_q  <= 1'b0;
    end
    else
    begin
      osc_cnt <= next_osc_cnt;
      tick_q  <= next_tick;
    end
  end

  assign cif.tick = tick_q;

  // ============================================================
  // Checks
  a_tick_spacing : assert property (@(posedge clk_sys) disable iff (rst)
    tick_q && $stable(cif.divider) |=> !tick_q)
    else $error("conversion tick spacing too short");
  c_tick_seen : cover property (@(posedge clk_sys) disable iff (rst) tick_q);
endmodule : asc_conv_clk

// file: rtl/asc_scan_config.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Bit 2 enables band gap sixth reference
// - Bit 1 enables band gap half reference
// - Bit 0 enables full reference; rest zero
// - Low scan bits select channels 0-15
// - Conversion period equals cycle times divider+1
// - Channel 26 selects core voltage, code 11010
// - Small package: channels 16-23 read zero
module asc_scan_config
  import asc_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Scan control
  input  wire logic        scan_run,
  // Analog controls
  output logic             sixth_reference_on,
  output logic             half_reference_on,
  output logic             full_reference_on,
  output logic      [4:0]  positive_input_selector,
  output logic             conv_tick
);
  typedef enum logic [1:0] {ASC_IDLE = 2'b01, ASC_SCAN = 2'b10} asc_state_e;

  localparam logic [15:0] HI_MASK = SMALL_PACKAGE ? ASC_HI_MASK_SMALL : ASC_HI_MASK_FULL;

  logic [15:0] ref_en, next_ref_en;
  logic [15:0] scan_lo, next_scan_lo;
  logic [15:0] scan_hi, next_scan_hi;
  logic [7:0]  conv_clock_divider, next_conv_clock_divider;
  logic [15:0] next_rdata;
  logic [4:0]  cur_ch, next_cur_ch;
  asc_state_e  state, next_state;
  logic [27:0] scan_channel_bits;
  logic [4:0]  found_ch;
  logic        found;
  logic        tick;

  asc_clk_if cif ();
  assign cif.divider = conv_clock_divider;
  assign tick        = cif.tick;

  asc_conv_clk u_conv_clk
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cif     (cif)
  );

  // ============================================================
  // Register writes and reads
  always_comb
  begin
    next_ref_en             = ref_en;
    next_scan_lo            = scan_lo;
    next_scan_hi            = scan_hi;
    next_conv_clock_divider = conv_clock_divider;
    next_rdata              = 16'h0000;
    if (wr)
    begin
      case (addr)
        ASC_OFF_REF_EN:  next_ref_en  = wdata & ASC_REF_MASK;
        ASC_OFF_SCAN_LO: next_scan_lo = wdata;
        ASC_OFF_SCAN_HI: next_scan_hi = wdata & HI_MASK;
        ASC_OFF_CLK_DIV: next_conv_clock_divider = wdata[7:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      case (addr)
        ASC_OFF_REF_EN:    next_rdata = ref_en;
        ASC_OFF_SCAN_LO:   next_rdata = scan_lo;
        ASC_OFF_SCAN_HI:   next_rdata = scan_hi;
        ASC_OFF_CLK_DIV:   next_rdata = {8'h00, conv_clock_divider};
        ASC_OFF_SCAN_STAT: next_rdata = {9'h000, state == ASC_SCAN, 1'b0, cur_ch};
        default:           next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ref_en             <= ASC_RESET_VAL;
      scan_lo            <= ASC_RESET_VAL;
      scan_hi            <= ASC_RESET_VAL;
      conv_clock_divider <= ASC_DIV_RESET;
      rdata              <= ASC_RESET_VAL;
    end
    else
    begin
      ref_en             <= next_ref_en;
      scan_lo            <= next_scan_lo;
      scan_hi            <= next_scan_hi;
      conv_clock_divider <= next_conv_clock_divider;
      rdata              <= next_rdata;
    end
  end

  // ============================================================
  // Reference enables
  assign sixth_reference_on = ref_en[ASC_BIT_SIXTH_REF];
  assign half_reference_on  = ref_en[ASC_BIT_HALF_REF];
  assign full_reference_on  = ref_en[ASC_BIT_FULL_REF];

  // ============================================================
  // Scan sequencer
  assign scan_channel_bits = {scan_hi[11:0], scan_lo};

  // Next selected channel above current, else lowest selected
  always_comb
  begin
    found    = 1'b0;
    found_ch = 5'h00;
    for (int i = ASC_NUM_CH - 1; i >= 0; i--)
    begin
      if (scan_channel_bits[i])
      begin
        found    = 1'b1;
        found_ch = 5'(i);
      end
    end
    for (int i = ASC_NUM_CH - 1; i >= 0; i--)
    begin
      if (scan_channel_bits[i] && (5'(i) > cur_ch) && (state == ASC_SCAN))
      begin
        found_ch = 5'(i);
      end
    end
  end

  always_comb
  begin
    next_state  = state;
    next_cur_ch = cur_ch;
    case (state)
      ASC_IDLE:
      begin
        if (scan_run && found)
        begin
          next_state  = ASC_SCAN;
          next_cur_ch = found_ch;
        end
      end
      ASC_SCAN:
      begin
        if (!scan_run || !found)
        begin
          next_state = ASC_IDLE;
        end
        else if (tick || !scan_channel_bits[cur_ch])
        begin
          next_cur_ch = found_ch;
        end
      end
      default:
      begin
        next_state = ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state     <= ASC_IDLE;
      cur_ch    <= 5'h00;
      conv_tick <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cur_ch    <= next_cur_ch;
      conv_tick <= tick && (state == ASC_SCAN);
    end
  end

  // Channel index to selector code
  always_comb
  begin
    if (state != ASC_SCAN)
      positive_input_selector = ASC_SEL_NONE;
    else
    begin
      case (cur_ch)
        5'(ASC_CH_HALF_REF):  positive_input_selector = ASC_SEL_HALF_REF;
        5'(ASC_CH_FULL_REF):  positive_input_selector = ASC_SEL_FULL_REF;
        5'(ASC_CH_CORE_V):    positive_input_selector = ASC_SEL_CORE_V;
        5'(ASC_CH_SIXTH_REF): positive_input_selector = ASC_SEL_SIXTH_REF;
        default:              positive_input_selector = cur_ch;
      endcase
    end
  end

  // ============================================================
  // Checks
  a_ref_upper_zero : assert property (@(posedge clk_sys) disable iff (rst)
    ref_en[15:3] == 13'h0000)
    else $error("reference register upper bits not zero");
  a_sixth_follows : assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == ASC_OFF_REF_EN |=> sixth_reference_on == $past(wdata[2]))
    else $error("sixth reference enable mismatch");
  a_half_follows : assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == ASC_OFF_REF_EN |=> half_reference_on == $past(wdata[1]))
    else $error("half reference enable mismatch");
  a_full_follows : assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == ASC_OFF_REF_EN |=> full_reference_on == $past(wdata[0]))
    else $error("full reference enable mismatch");
  a_low_readback : assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == ASC_OFF_SCAN_LO ##1 rd && addr == ASC_OFF_SCAN_LO |=> rdata == $past(wdata, 2))
    else $error("low scan readback mismatch");
  a_high_mask : assert property (@(posedge clk_sys) disable iff (rst)
    (scan_hi & ~HI_MASK) == 16'h0000)
    else $error("high scan reserved bits set");
  a_core_code : assert property (@(posedge clk_sys) disable iff (rst)
    state == ASC_SCAN && cur_ch == 5'd26 |-> positive_input_selector == 5'b11010)
    else $error("core voltage selector wrong");
  a_small_pkg : assert property (@(posedge clk_sys) disable iff (rst)
    SMALL_PACKAGE |-> scan_hi[7:0] == 8'h00)
    else $error("absent channels hold bits");
  a_scan_selected : assert property (@(posedge clk_sys) disable iff (rst)
    state == ASC_SCAN && $stable(scan_channel_bits) |-> scan_channel_bits[cur_ch])
    else $error("scan on unselected channel");
  c_scan_wrap : cover property (@(posedge clk_sys) disable iff (rst)
    state == ASC_SCAN && tick && found_ch < cur_ch);
  c_core_scan : cover property (@(posedge clk_sys) disable iff (rst)
    positive_input_selector == ASC_SEL_CORE_V);
  c_all_refs : cover property (@(posedge clk_sys) disable iff (rst)
    sixth_reference_on && half_reference_on && full_reference_on);
endmodule : asc_scan_config

// file: tb/tb_asc_scan_config.sv
`timescale 1ns/1ps
module tb_asc_scan_config
  import asc_pkg::*;
;
  // ============================================================
  // Signals
  logic        clk_sys;
  logic        rst;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        scan_run;
  logic [15:0] rdata;
  logic [15:0] rdata_s;
  logic        sixth_reference_on;
  logic        half_reference_on;
  logic        full_reference_on;
  logic [4:0]  positive_input_selector;
  logic        conv_tick;
  int          miscompares;
  int          n_tests;
  logic [15:0] got;
  logic [15:0] got_s;
  int          n;
  logic [15:0] ref_vals [5] = '{16'hffff, 16'h0004, 16'h0002, 16'h0001, 16'h0000};
  logic [4:0]  seq [3];

  // ============================================================
  // Devices: full and small package
  asc_scan_config #(.SMALL_PACKAGE(1'b0)) asc_scan_config_inst (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr                      (wr),
    .rd                      (rd),
    .rdata                   (rdata),
    .scan_run                (scan_run),
    .sixth_reference_on      (sixth_reference_on),
    .half_reference_on       (half_reference_on),
    .full_reference_on       (full_reference_on),
    .positive_input_selector (positive_input_selector),
    .conv_tick               (conv_tick)
  );

  asc_scan_config #(.SMALL_PACKAGE(1'b1)) asc_scan_config_small_inst (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr                      (wr),
    .rd                      (rd),
    .rdata                   (rdata_s),
    .scan_run                (scan_run),
    .sixth_reference_on      (),
    .half_reference_on       (),
    .full_reference_on       (),
    .positive_input_selector (),
    .conv_tick               ()
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ============================================================
  // Tasks
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] a, output logic [15:0] d, output logic [15:0] ds);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d  = rdata;
    ds = rdata_s;
  endtask : read_reg

  task automatic wait_sel(output int cnt);
    logic [4:0] p;
    p   = positive_input_selector;
    cnt = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (positive_input_selector === p && cnt < 100);
    if (cnt >= 100)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : wait_sel

  // ============================================================
  // Main sequence
  initial
  begin
    rst = 1'b1; addr = 4'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0; scan_run = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset state
    for (int i = 0; i < 4; i++)
    begin
      read_reg(4'(2 * i), got, got_s);
      check(got, 16'h0000);
    end
    check({11'h000, positive_input_selector}, {11'h000, ASC_SEL_NONE});
    // Reference enables
    foreach (ref_vals[i])
    begin
      write_reg(ASC_OFF_REF_EN, ref_vals[i]);
      check({13'h0000, sixth_reference_on, half_reference_on, full_reference_on}, ref_vals[i] & 16'h0007);
      read_reg(ASC_OFF_REF_EN, got, got_s);
      check(got, ref_vals[i] & 16'h0007);
    end
    @(posedge clk_sys);
    #1;
    check(rdata, 16'h0000);
    // Scan select registers
    write_reg(ASC_OFF_SCAN_LO, 16'hffff);
    read_reg(ASC_OFF_SCAN_LO, got, got_s);
    check(got, 16'hffff);
    write_reg(ASC_OFF_SCAN_HI, 16'hffff);
    read_reg(ASC_OFF_SCAN_HI, got, got_s);
    check(got, 16'h0fff);
    check(got_s, 16'h0f00);
    write_reg(4'ha, 16'hffff);
    read_reg(4'ha, got, got_s);
    check(got, 16'h0000);
    // Scan of channels 0, 2 and core voltage
    write_reg(ASC_OFF_SCAN_LO, 16'h0005);
    write_reg(ASC_OFF_SCAN_HI, 16'h0400);
    seq = '{5'h02, ASC_SEL_CORE_V, 5'h00};
    for (int dv = 0; dv < 3; dv += 2)
    begin
      write_reg(ASC_OFF_CLK_DIV, 16'(dv));
      read_reg(ASC_OFF_CLK_DIV, got, got_s);
      check(got, 16'(dv));
      @(posedge clk_sys);
      scan_run <= 1'b1;
      wait_sel(n);
      check({11'h000, positive_input_selector}, 16'h0000);
      foreach (seq[k])
      begin
        wait_sel(n);
        check({11'h000, positive_input_selector}, {11'h000, seq[k]});
        check({15'h0000, conv_tick}, 16'h0001);
        // First interval depends on free-running divider phase
        if (k == 0)
          check(16'(n <= ASC_OSC_PER_CYC * (dv + 1)), 16'h0001);
        else
          check(16'(n), 16'(ASC_OSC_PER_CYC * (dv + 1)));
      end
      read_reg(ASC_OFF_SCAN_STAT, got, got_s);
      check(got, 16'h0040);
      @(posedge clk_sys);
      scan_run <= 1'b0;
      wait_sel(n);
      check({11'h000, positive_input_selector}, {11'h000, ASC_SEL_NONE});
    end
    tally_and_finish();
  end
endmodule : tb_asc_scan_config
